// ---- sport_pkg.sv ----
// Package: register map, limits, reset values and timing of the serial port
package sport_pkg;

  // Configuration database locations
  localparam logic [15:0] REG_WR_START  = 16'h1388;
  localparam logic [15:0] REG_WR_COUNT  = 16'h1389;
  localparam logic [15:0] REG_RD_START  = 16'h138A;
  localparam logic [15:0] REG_RD_COUNT  = 16'h138B;
  localparam logic [15:0] REG_FAIL_LIM  = 16'h138C;
  localparam logic [15:0] REG_STAT_LOC  = 16'h138D;
  localparam logic [15:0] REG_ENABLE    = 16'h1392;
  localparam logic [15:0] REG_ROLE      = 16'h1393;
  localparam logic [15:0] REG_FLT_MODE  = 16'h1394;
  localparam logic [15:0] REG_FLT_START = 16'h1395;
  localparam logic [15:0] REG_FLT_BASE  = 16'h1396;
  localparam logic [15:0] REG_FRAMING   = 16'h1397;
  localparam logic [15:0] REG_RATE      = 16'h1398;
  localparam logic [15:0] REG_PARITY    = 16'h1399;
  localparam logic [15:0] REG_WIDTH     = 16'h139A;
  localparam logic [15:0] REG_STOPS     = 16'h139B;
  localparam logic [15:0] REG_PRE_MS    = 16'h139C;
  localparam logic [15:0] REG_POST_MS   = 16'h139D;
  localparam logic [15:0] REG_RESP_MS   = 16'h139E;
  localparam logic [15:0] REG_CTS_USE   = 16'h139F;

  // Valid ranges
  localparam logic [15:0] START_MAX = 16'h1387;
  localparam logic [15:0] COUNT_MAX = 16'h1388;
  localparam logic [15:0] STAT_MAX  = 16'h134C;
  localparam logic [3:0]  WIDTH_MIN = 4'h5;
  localparam logic [3:0]  WIDTH_MAX = 4'h8;

  // Parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  // Function codes that carry register data
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_WR_ONE  = 8'h06;
  localparam logic [7:0] FC_WR_MANY = 8'h10;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 32'h00000008;
  localparam int unsigned MS_TIME_NS    = 32'h000F4240;
  localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CLOCK_HZ      = 32'h07735940;

  typedef struct packed {
    logic        en;
    logic [1:0]  role;
    logic        flt;
    logic [15:0] fstart;
    logic [15:0] fbase;
    logic        ascii;
    logic [15:0] rate;
    logic [1:0]  par;
    logic [3:0]  width;
    logic [1:0]  stops;
    logic [15:0] pre_ms;
    logic [15:0] post_ms;
    logic [15:0] resp_ms;
    logic        cts;
  } port_cfg_s;

  // Port settings after reset: off, master, RTU, 9600 8N1, no delays
  localparam port_cfg_s PORT_RST = '{
    en: 1'h0, role: 2'h0, flt: 1'h0, fstart: 16'h0000,
    fbase: 16'h0000, ascii: 1'h0, rate: 16'h2580, par: PAR_NONE,
    width: 4'h8, stops: 2'h1, pre_ms: 16'h0000, post_ms: 16'h0000,
    resp_ms: 16'h0000, cts: 1'h0};

endpackage : sport_pkg

// ---- sport_cfg.sv ----
// Serial port configuration store with RTS timed character transmitter
`timescale 1ns/1ns

// How it works
// - Host loads configuration after reset; all of it stays readable.
// - Host-to-database start register kept only in range 0 to 4999.
// - Host-to-database register count kept only in range 0 to 5000.
// - Database-to-host start register kept only in range 0 to 4999.
// - Database-to-host register count kept only in range 0 to 5000.
// - Successive transfer errors reaching a nonzero limit stop the port.
// - Negative status location disables status copy; 0..4940 sets base.
// - Port runs only when its enable value is 1.
// - Role code selects master or one of three slave behaviours.
// - Real value mode covers function codes 3, 6 and 16.
// - Requests at or above the threshold are real value requests.
// - Real value requests map from the real value base register.
// - Framing selector picks RTU at 0 and ASCII at 1.
// - Line rate literal, with 384, 576, 115 as short codes.
// - Configured parity applies to sent and checked characters.
// - Characters carry 5 to 8 data bits.
// - One or two stop bits follow each sent character.
// - After RTS rises, wait the pre-send delay before data.
// - After the last byte, wait the post-send delay before RTS low.
// - Reply pre-delay runs before RTS rises.
// - With CTS use on, sending waits for CTS high.
module sport_cfg
  import sport_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES,
  parameter int unsigned CLK_HZ = CLOCK_HZ
)(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Host configuration port
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [15:0] i_cfg_addr,
  input  wire logic [15:0] i_cfg_wdata,
  input  wire logic        i_init_done,
  output logic      [15:0] o_cfg_rdata,
  output logic             o_cfg_ready,
  // Host transfer window and health
  input  wire logic        i_xfer_ok,
  input  wire logic        i_xfer_err,
  output logic      [15:0] o_wr_start,
  output logic      [15:0] o_wr_count,
  output logic      [15:0] o_rd_start,
  output logic      [15:0] o_rd_count,
  output logic             o_ports_shut,
  output logic             o_status_en,
  output logic      [15:0] o_status_base,
  // Port mode
  output logic             o_port_run,
  output logic             o_master,
  output logic             o_pass_raw,
  output logic             o_pass_fmt,
  output logic             o_ascii,
  // Register request mapping
  input  wire logic        i_req_valid,
  input  wire logic  [7:0] i_req_fc,
  input  wire logic [15:0] i_req_reg,
  output logic             o_req_done,
  output logic             o_req_float,
  output logic      [15:0] o_req_db,
  // Byte stream to send
  input  wire logic        i_tx_valid,
  input  wire logic  [7:0] i_tx_data,
  input  wire logic        i_tx_last,
  output logic             o_tx_ready,
  // Received character check
  input  wire logic        i_rx_valid,
  input  wire logic  [7:0] i_rx_data,
  input  wire logic        i_rx_par,
  output logic             o_rx_par_err,
  // Serial line
  input  wire logic        i_cts,
  output logic             o_rts,
  output logic             o_txd
);

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_RESP, SQ_RTS_ON, SQ_CTS, SQ_SEND, SQ_POST
  } seq_e;

  port_cfg_s   port_ff;
  logic [15:0] wr_start_ff, wr_count_ff, rd_start_ff, rd_count_ff;
  logic [15:0] fail_lim_ff, stat_loc_ff, fail_cnt_ff, rdata_ff;
  logic        cfg_ready_ff, shut_ff, run_ff, stat_en_ff;
  logic        req_done_ff, req_float_ff, rx_err_ff;
  logic [15:0] req_db_ff;
  logic [23:0] ms_cnt_ff;
  logic        ms_tick_ff;
  seq_e        seq_ff;
  logic        rts_ff, ready_ff, last_ff;
  logic [15:0] dly_ff;
  logic        busy_ff, txd_ff;
  logic [11:0] shift_ff;
  logic [3:0]  bits_ff;
  logic [23:0] baud_cnt_ff;
  logic [23:0] wr_div, bit_div;
  logic [15:0] rd_val, nxt_fail;
  logic [11:0] frame;
  logic [3:0]  nbits;
  logic        take, bit_tick, char_done, req_flt, dly_start;
  logic [2:0]  mode_ff;

  // Clock cycles per bit for each accepted line rate; zero if not accepted
  function automatic logic [23:0] baud_div(input logic [15:0] code);
    int unsigned d;
    d = 0;
    case (code)
      16'h006E: d = CLK_HZ / 32'h0000006E;
      16'h0096: d = CLK_HZ / 32'h00000096;
      16'h012C: d = CLK_HZ / 32'h0000012C;
      16'h0258: d = CLK_HZ / 32'h00000258;
      16'h04B0: d = CLK_HZ / 32'h000004B0;
      16'h0960: d = CLK_HZ / 32'h00000960;
      16'h12C0: d = CLK_HZ / 32'h000012C0;
      16'h2580: d = CLK_HZ / 32'h00002580;
      16'h4B00: d = CLK_HZ / 32'h00004B00;
      16'h7080: d = CLK_HZ / 32'h00007080;
      16'h0180: d = CLK_HZ / 32'h00009600;
      16'h0240: d = CLK_HZ / 32'h0000E100;
      16'h0073: d = CLK_HZ / 32'h0001C200;
      default:  d = 0;
    endcase
    if (d == 0 && code inside {16'h006E, 16'h0096, 16'h012C})
      d = 1;
    return 24'(d);
  endfunction : baud_div

  // Parity bit over the low w data bits
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [3:0] w,
                                   input logic [1:0] p);
    logic [7:0] m;
    m = d & 8'(8'hFF >> (4'h8 - w));
    return (p == PAR_ODD) ? ~(^m) : (^m);
  endfunction : par_bit

  always_comb wr_div = baud_div(i_cfg_wdata);
  always_comb bit_div = baud_div(port_ff.rate);

  // Configuration writes; an out of range value leaves the old one
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      wr_start_ff <= 16'h0000;
      wr_count_ff <= 16'h0000;
      rd_start_ff <= 16'h0000;
      rd_count_ff <= 16'h0000;
      fail_lim_ff <= 16'h0000;
      stat_loc_ff <= 16'hFFFF;
      port_ff     <= PORT_RST;
    end
    else if (i_cfg_wr)
    begin
      case (i_cfg_addr)
        REG_WR_START:
          if (i_cfg_wdata <= START_MAX) wr_start_ff <= i_cfg_wdata;
        REG_WR_COUNT:
          if (i_cfg_wdata <= COUNT_MAX) wr_count_ff <= i_cfg_wdata;
        REG_RD_START:
          if (i_cfg_wdata <= START_MAX) rd_start_ff <= i_cfg_wdata;
        REG_RD_COUNT:
          if (i_cfg_wdata <= COUNT_MAX) rd_count_ff <= i_cfg_wdata;
        REG_FAIL_LIM: fail_lim_ff <= i_cfg_wdata;
        REG_STAT_LOC:
          if (i_cfg_wdata[15] || i_cfg_wdata <= STAT_MAX)
            stat_loc_ff <= i_cfg_wdata;
        REG_ENABLE:
          if (i_cfg_wdata <= 16'h0001) port_ff.en <= i_cfg_wdata[0];
        REG_ROLE:
          if (i_cfg_wdata <= 16'h0003) port_ff.role <= i_cfg_wdata[1:0];
        REG_FLT_MODE:
          if (i_cfg_wdata <= 16'h0001) port_ff.flt <= i_cfg_wdata[0];
        REG_FLT_START: port_ff.fstart <= i_cfg_wdata;
        REG_FLT_BASE:  port_ff.fbase <= i_cfg_wdata;
        REG_FRAMING:
          if (i_cfg_wdata <= 16'h0001) port_ff.ascii <= i_cfg_wdata[0];
        REG_RATE:
          if (wr_div != 24'h000000) port_ff.rate <= i_cfg_wdata;
        REG_PARITY:
          if (i_cfg_wdata <= 16'h0002) port_ff.par <= i_cfg_wdata[1:0];
        REG_WIDTH:
          if (i_cfg_wdata >= 16'(WIDTH_MIN) && i_cfg_wdata <= 16'(WIDTH_MAX))
            port_ff.width <= i_cfg_wdata[3:0];
        REG_STOPS:
          if (i_cfg_wdata == 16'h0001 || i_cfg_wdata == 16'h0002)
            port_ff.stops <= i_cfg_wdata[1:0];
        REG_PRE_MS:  port_ff.pre_ms <= i_cfg_wdata;
        REG_POST_MS: port_ff.post_ms <= i_cfg_wdata;
        REG_RESP_MS: port_ff.resp_ms <= i_cfg_wdata;
        REG_CTS_USE:
          if (i_cfg_wdata <= 16'h0001) port_ff.cts <= i_cfg_wdata[0];
        default: ;
      endcase
    end
  end

  // Read back; unmapped locations read zero
  always_comb
  begin
    case (i_cfg_addr)
      REG_WR_START:  rd_val = wr_start_ff;
      REG_WR_COUNT:  rd_val = wr_count_ff;
      REG_RD_START:  rd_val = rd_start_ff;
      REG_RD_COUNT:  rd_val = rd_count_ff;
      REG_FAIL_LIM:  rd_val = fail_lim_ff;
      REG_STAT_LOC:  rd_val = stat_loc_ff;
      REG_ENABLE:    rd_val = 16'(port_ff.en);
      REG_ROLE:      rd_val = 16'(port_ff.role);
      REG_FLT_MODE:  rd_val = 16'(port_ff.flt);
      REG_FLT_START: rd_val = port_ff.fstart;
      REG_FLT_BASE:  rd_val = port_ff.fbase;
      REG_FRAMING:   rd_val = 16'(port_ff.ascii);
      REG_RATE:      rd_val = port_ff.rate;
      REG_PARITY:    rd_val = 16'(port_ff.par);
      REG_WIDTH:     rd_val = 16'(port_ff.width);
      REG_STOPS:     rd_val = 16'(port_ff.stops);
      REG_PRE_MS:    rd_val = port_ff.pre_ms;
      REG_POST_MS:   rd_val = port_ff.post_ms;
      REG_RESP_MS:   rd_val = port_ff.resp_ms;
      REG_CTS_USE:   rd_val = 16'(port_ff.cts);
      default:       rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      rdata_ff <= 16'h0000;
    else if (i_cfg_rd)
      rdata_ff <= rd_val;
  end

  // Initialization handshake and run state
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cfg_ready_ff <= 1'b0;
      run_ff       <= 1'b0;
      stat_en_ff   <= 1'b0;
    end
    else
    begin
      if (i_init_done)
        cfg_ready_ff <= 1'b1;
      run_ff     <= cfg_ready_ff && port_ff.en && !shut_ff;
      stat_en_ff <= !stat_loc_ff[15];
    end
  end

  // Successive transfer failures; a good transfer restarts the count
  always_comb
  begin
    nxt_fail = fail_cnt_ff;
    if (i_xfer_ok)
      nxt_fail = 16'h0000;
    else if (i_xfer_err && fail_cnt_ff != 16'hFFFF)
      nxt_fail = fail_cnt_ff + 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      fail_cnt_ff <= 16'h0000;
      shut_ff     <= 1'b0;
    end
    else
    begin
      fail_cnt_ff <= nxt_fail;
      shut_ff     <= fail_lim_ff != 16'h0000
                     && nxt_fail >= fail_lim_ff;
    end
  end

  // Real value request mapping
  always_comb
    req_flt = port_ff.flt && i_req_reg >= port_ff.fstart
              && i_req_fc inside {FC_RD_HOLD, FC_WR_ONE, FC_WR_MANY};

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      req_done_ff  <= 1'b0;
      req_float_ff <= 1'b0;
      req_db_ff    <= 16'h0000;
    end
    else
    begin
      req_done_ff <= i_req_valid;
      if (i_req_valid)
      begin
        req_float_ff <= req_flt;
        req_db_ff    <= req_flt
                        ? 16'(port_ff.fbase + (i_req_reg - port_ff.fstart))
                        : i_req_reg;
      end
    end
  end

  // A new delay restarts the count, so no delay ends early
  always_comb
    dly_start = (seq_ff == SQ_IDLE && i_tx_valid)
                || (seq_ff == SQ_RESP && dly_ff == 16'h0000)
                || (seq_ff == SQ_SEND && char_done && last_ff);

  // Millisecond tick
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || dly_start || ms_cnt_ff == 24'(MS_CYC - 1))
      ms_cnt_ff <= 24'h000000;
    else
      ms_cnt_ff <= ms_cnt_ff + 24'h000001;
    ms_tick_ff <= i_nrst && !dly_start
                  && ms_cnt_ff == 24'(MS_CYC - 1);
  end

  // Character framing: start, data, optional parity, stop bits
  always_comb
  begin
    frame = 12'hFFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < int'(port_ff.width))
        frame[i + 1] = i_tx_data[i];
    if (port_ff.par != PAR_NONE)
      frame[port_ff.width + 4'h1] =
        par_bit(i_tx_data, port_ff.width, port_ff.par);
    nbits = 4'h1 + port_ff.width + 4'(port_ff.par != PAR_NONE)
            + 4'(port_ff.stops);
  end

  assign take      = ready_ff && i_tx_valid;
  assign bit_tick  = busy_ff && baud_cnt_ff == bit_div - 24'h000001;
  assign char_done = bit_tick && bits_ff == 4'h0;

  // Bit shifter
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      busy_ff     <= 1'b0;
      txd_ff      <= 1'b1;
      shift_ff    <= 12'hFFF;
      bits_ff     <= 4'h0;
      baud_cnt_ff <= 24'h000000;
    end
    else if (take)
    begin
      busy_ff     <= 1'b1;
      txd_ff      <= frame[0];
      shift_ff    <= frame >> 1;
      bits_ff     <= nbits - 4'h1;
      baud_cnt_ff <= 24'h000000;
    end
    else if (busy_ff)
    begin
      baud_cnt_ff <= bit_tick ? 24'h000000 : baud_cnt_ff + 24'h000001;
      if (char_done)
      begin
        busy_ff <= 1'b0;
        txd_ff  <= 1'b1;
      end
      else if (bit_tick)
      begin
        txd_ff   <= shift_ff[0];
        shift_ff <= shift_ff >> 1;
        bits_ff  <= bits_ff - 4'h1;
      end
    end
  end

  // Received character parity check
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      rx_err_ff <= 1'b0;
    else
      rx_err_ff <= i_rx_valid && port_ff.par != PAR_NONE
        && i_rx_par != par_bit(i_rx_data, port_ff.width, port_ff.par);
  end

  // RTS sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || !run_ff)
    begin
      seq_ff   <= SQ_IDLE;
      rts_ff   <= 1'b0;
      ready_ff <= 1'b0;
      last_ff  <= 1'b0;
      dly_ff   <= 16'h0000;
    end
    else
    begin
      unique case (seq_ff)
        SQ_IDLE:
          if (i_tx_valid)
          begin
            seq_ff <= SQ_RESP;
            dly_ff <= (port_ff.role != 2'h0) ? port_ff.resp_ms
                                             : 16'h0000;
          end
        SQ_RESP:
          if (dly_ff == 16'h0000)
          begin
            seq_ff <= SQ_RTS_ON;
            rts_ff <= 1'b1;
            dly_ff <= port_ff.pre_ms;
          end
          else if (ms_tick_ff)
            dly_ff <= dly_ff - 16'h0001;
        SQ_RTS_ON:
          if (dly_ff == 16'h0000)
            seq_ff <= SQ_CTS;
          else if (ms_tick_ff)
            dly_ff <= dly_ff - 16'h0001;
        SQ_CTS:
          if (!port_ff.cts || i_cts)
          begin
            seq_ff   <= SQ_SEND;
            ready_ff <= 1'b1;
          end
        SQ_SEND:
          if (take)
          begin
            ready_ff <= 1'b0;
            last_ff  <= i_tx_last;
          end
          else if (char_done)
          begin
            if (last_ff)
            begin
              seq_ff <= SQ_POST;
              dly_ff <= port_ff.post_ms;
            end
            else
              ready_ff <= 1'b1;
          end
        SQ_POST:
          if (dly_ff == 16'h0000)
          begin
            seq_ff  <= SQ_IDLE;
            rts_ff  <= 1'b0;
            last_ff <= 1'b0;
          end
          else if (ms_tick_ff)
            dly_ff <= dly_ff - 16'h0001;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      mode_ff <= 3'h4;
    else
      mode_ff <= {port_ff.role == 2'h0, port_ff.role == 2'h2,
                  port_ff.role == 2'h3};
  end

  assign o_cfg_rdata   = rdata_ff;
  assign o_cfg_ready   = cfg_ready_ff;
  assign o_wr_start    = wr_start_ff;
  assign o_wr_count    = wr_count_ff;
  assign o_rd_start    = rd_start_ff;
  assign o_rd_count    = rd_count_ff;
  assign o_ports_shut  = shut_ff;
  assign o_status_en   = stat_en_ff;
  assign o_status_base = stat_loc_ff;
  assign o_port_run    = run_ff;
  assign o_master      = mode_ff[2];
  assign o_pass_raw    = mode_ff[1];
  assign o_pass_fmt    = mode_ff[0];
  assign o_ascii       = port_ff.ascii;
  assign o_req_done    = req_done_ff;
  assign o_req_float   = req_float_ff;
  assign o_req_db      = req_db_ff;
  assign o_tx_ready    = ready_ff;
  assign o_rx_par_err  = rx_err_ff;
  assign o_rts         = rts_ff;
  assign o_txd         = txd_ff;

  rts_idle_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      seq_ff == SQ_IDLE |-> !rts_ff)
    else $error("RTS high while idle");

  presend_quiet_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(rts_ff) |-> !ready_ff && txd_ff)
    else $error("Data offered as RTS rose");

  cts_gate_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      seq_ff == SQ_CTS && port_ff.cts && !i_cts && run_ff
      |=> seq_ff != SQ_SEND)
    else $error("Sending started without CTS");

  fail_stop_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      shut_ff |=> !run_ff)
    else $error("Port runs after failure limit");

  no_limit_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      fail_lim_ff == 16'h0000 |=> !shut_ff)
    else $error("Port stopped with zero limit");

  disable_rts_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      !port_ff.en ##1 !port_ff.en |=> !rts_ff)
    else $error("RTS driven on disabled port");

  float_map_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_req_valid && req_flt |=> req_float_ff && req_done_ff)
    else $error("Real value request not flagged");

  resp_order_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(rts_ff) |-> $past(seq_ff) == SQ_RESP)
    else $error("RTS rose without reply pre-delay");

  width_keep_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && i_cfg_addr == REG_WIDTH && i_cfg_wdata > 16'h0008
      |=> port_ff.width == $past(port_ff.width))
    else $error("Out of range width accepted");

  status_off_a:
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      stat_loc_ff[15] ##1 stat_loc_ff[15] |-> !stat_en_ff)
    else $error("Status copy on with negative location");

endmodule : sport_cfg

// ---- sport_node.sv ----
// Remote serial node: clear-to-send answer and character capture
`timescale 1ns/1ns
module sport_node #(
  parameter int BIT_DIV = 10,
  parameter int CTS_LAG = 45
)(
  input  wire logic       i_clk,
  input  wire logic       i_rts,
  input  wire logic       i_txd,
  output logic            o_cts,
  output logic      [7:0] o_byte
);
  int n = 0;
  initial o_cts = 1'b0;
  initial o_byte = 8'h00;
  // Slow modem: CTS rises a while after RTS, drops with it
  always @(posedge i_clk)
  begin
    n <= i_rts ? n + 1 : 0;
    o_cts <= i_rts && n >= CTS_LAG;
  end
  // Mid-bit sampling of eight data bits, LSB first
  always
  begin
    @(negedge i_txd);
    repeat (BIT_DIV * 3 / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++)
    begin
      o_byte[i] = i_txd;
      repeat (BIT_DIV) @(posedge i_clk);
    end
  end
endmodule : sport_node

// ---- sport_cfg_test.sv ----
// Bench for the serial port configuration store and sender
`timescale 1ns/1ns
module sport_cfg_test;
  import sport_pkg::*;
  logic        i_clk = 1'b0, i_nrst = 1'b0, i_cfg_wr = 1'b0;
  logic        i_cfg_rd = 1'b0, i_req_valid = 1'b0, i_tx_valid = 1'b0;
  logic        i_tx_last = 1'b1, i_rx_valid = 1'b0, i_rx_par = 1'b0;
  logic [15:0] i_cfg_addr = 16'h0000, i_cfg_wdata = 16'h0000;
  logic [15:0] i_req_reg = 16'h0000, o_cfg_rdata, o_wr_start, o_req_db;
  logic [15:0] o_status_base, e, o_wr_count, o_rd_start, o_rd_count;
  logic [7:0]  i_req_fc = 8'h00, i_tx_data = 8'hA5, i_rx_data = 8'h07;
  logic [7:0]  got;
  logic [2:0]  pl = 3'h0;
  logic        o_cfg_ready, o_ports_shut, o_status_en, o_port_run;
  logic        o_master, o_pass_raw, o_pass_fmt, o_ascii, o_req_done;
  logic        o_req_float, o_tx_ready, o_rx_par_err, i_cts, o_rts, o_txd;
  wire  [1:0]  wv = {o_tx_ready, o_rts};
  int          error_cnt = 0, cmp_count = 0, cyc = 0, t;

  sport_cfg #(.MS_CYC(10), .CLK_HZ(1152000)) dut_u (
    .i_clk, .i_nrst, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata,
    .i_init_done(pl[2]), .i_xfer_ok(pl[1]), .i_xfer_err(pl[0]),
    .o_cfg_rdata, .o_cfg_ready, .o_wr_start, .o_wr_count,
    .o_rd_start, .o_rd_count, .o_ports_shut, .o_status_en,
    .o_status_base, .o_port_run, .o_master, .o_pass_raw, .o_pass_fmt,
    .o_ascii, .i_req_valid, .i_req_fc, .i_req_reg, .o_req_done,
    .o_req_float, .o_req_db, .i_tx_valid, .i_tx_data, .i_tx_last,
    .o_tx_ready, .i_rx_valid, .i_rx_data, .i_rx_par, .o_rx_par_err,
    .i_cts, .o_rts, .o_txd);
  sport_node #(.BIT_DIV(10), .CTS_LAG(45)) node_u (
    .i_clk, .i_rts(o_rts), .i_txd(o_txd), .o_cts(i_cts), .o_byte(got));

  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report;
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] s, x);
    cmp_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick
  // Write a word, read it back, expect x
  task automatic wr(input logic [15:0] a, d, x);
    @(posedge i_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    i_cfg_rd <= 1'b1;
    @(posedge i_clk);
    i_cfg_rd <= 1'b0;
    #1 chk("cfg_rdata", o_cfg_rdata, x);
  endtask : wr
  task automatic pulse(input int k);
    @(posedge i_clk);
    pl[k] <= 1'b1;
    @(posedge i_clk);
    pl[k] <= 1'b0;
  endtask : pulse
  task automatic rq(input logic [7:0] f, input logic [15:0] r, x);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req_fc <= f;
    i_req_reg <= r;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1 chk("req_db", o_req_db, x);
  endtask : rq
  task automatic rx(input logic p, x);
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    i_rx_par <= p;
    @(posedge i_clk);
    i_rx_valid <= 1'b0;
    #1 chk("par_err", 16'(o_rx_par_err), 16'(x));
  endtask : rx
  task automatic wait_lvl(input int k, input logic v);
    t = 0;
    while (wv[k] !== v && t < 500)
    begin
      tick();
      t++;
    end
  endtask : wait_lvl
  // Frame; f selects CTS use, two stop bits and a second byte
  task automatic frame(input int f);
    wr(REG_CTS_USE, 16'(f), 16'(f));
    wr(REG_STOPS, 16'(f + 1), 16'(f + 1));
    @(posedge i_clk);
    i_tx_valid <= 1'b1;
    i_tx_last <= f == 0;
    wait_lvl(0, 1'b1);
    chk("reply_wait", 16'(t >= 10 && t <= 25), 16'h0001);
    wait_lvl(1, 1'b1);
    t = t - 25 * f;
    chk("presend", 16'(t >= 20 && t <= 33), 16'h0001);
    if (f == 1)
    begin
      @(posedge i_clk);
      i_tx_last <= 1'b1;
      wait_lvl(1, 1'b0);
      wait_lvl(1, 1'b1);
      chk("next_byte", 16'(t >= 105 && t <= 112), 16'h0001);
    end
    @(posedge i_clk);
    i_tx_valid <= 1'b0;
    wait_lvl(0, 1'b0);
    t = t - 10 * f;
    chk("postsend", 16'(t >= 110 && t <= 125), 16'h0001);
    chk("byte", 16'(got), 16'h00A5);
    chk("txd_idle", 16'(o_txd), 16'h0001);
  endtask : frame

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    tick();
    chk("idle", 16'({o_rts, o_txd, o_cfg_ready}), 16'h0002);
    wr(REG_WR_START, 16'h1387, 16'h1387);
    wr(REG_WR_START, 16'h1388, 16'h1387);
    wr(REG_WR_COUNT, 16'h1389, 16'h0000);
    wr(REG_WR_COUNT, 16'h1388, 16'h1388);
    wr(REG_RD_START, 16'h1388, 16'h0000);
    wr(REG_RD_START, 16'h1387, 16'h1387);
    wr(REG_RD_COUNT, 16'h1388, 16'h1388);
    wr(REG_RD_COUNT, 16'h1389, 16'h1388);
    chk("wr_start", o_wr_start, 16'h1387);
    chk("wr_count", o_wr_count, 16'h1388);
    chk("rd_start", o_rd_start, 16'h1387);
    chk("rd_count", o_rd_count, 16'h1388);
    wr(REG_STAT_LOC, 16'h134D, 16'hFFFF);
    wr(REG_STAT_LOC, 16'h134C, 16'h134C);
    chk("stat", 16'(o_status_en) ^ o_status_base, 16'h134D);
    wr(REG_STAT_LOC, 16'hFFFF, 16'hFFFF);
    chk("stat_off", 16'(o_status_en), 16'h0000);
    wr(REG_WIDTH, 16'h0004, 16'h0008);
    wr(REG_WIDTH, 16'h0005, 16'h0005);
    wr(REG_WIDTH, 16'h0009, 16'h0005);
    wr(REG_WIDTH, 16'h0008, 16'h0008);
    wr(REG_STOPS, 16'h0003, 16'h0001);
    wr(REG_RATE, 16'h0180, 16'h0180);
    wr(REG_RATE, 16'h0240, 16'h0240);
    wr(REG_RATE, 16'h0181, 16'h0240);
    wr(REG_RATE, 16'h0073, 16'h0073);
    wr(REG_ENABLE, 16'h0002, 16'h0000);
    wr(16'h0000, 16'h1234, 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      wr(REG_ROLE, 16'(r), 16'(r));
      wr(REG_FRAMING, 16'(r % 2), 16'(r % 2));
      e = 16'({r == 0, r == 2, r == 3, r % 2 == 1});
      chk("mode", 16'({o_master, o_pass_raw, o_pass_fmt, o_ascii}), e);
    end
    wr(REG_ROLE, 16'h0004, 16'h0003);
    for (int p = 0; p < 4; p++)
    begin
      wr(REG_PARITY, 16'(p), p < 3 ? 16'(p) : 16'h0002);
      rx(1'b0, p >= 2);
      rx(1'b1, p == 1);
    end
    wr(REG_FLT_MODE, 16'h0001, 16'h0001);
    wr(REG_FLT_START, 16'h0064, 16'h0064);
    wr(REG_FLT_BASE, 16'h07D0, 16'h07D0);
    rq(8'h03, 16'h0064, 16'h07D0);
    chk("float", 16'({o_req_done, o_req_float}), 16'h0003);
    rq(8'h10, 16'h0069, 16'h07D5);
    rq(8'h06, 16'h0063, 16'h0063);
    rq(8'h04, 16'h00C8, 16'h00C8);
    chk("float", 16'({o_req_done, o_req_float}), 16'h0002);
    wr(REG_FLT_MODE, 16'h0000, 16'h0000);
    rq(8'h06, 16'h00C8, 16'h00C8);
    wr(REG_PARITY, 16'h0000, 16'h0000);
    wr(REG_ENABLE, 16'h0001, 16'h0001);
    wr(REG_ROLE, 16'h0001, 16'h0001);
    wr(REG_PRE_MS, 16'h0002, 16'h0002);
    wr(REG_POST_MS, 16'h0001, 16'h0001);
    wr(REG_RESP_MS, 16'h0001, 16'h0001);
    chk("run_early", 16'(o_port_run), 16'h0000);
    pulse(2);
    tick();
    chk("run", 16'({o_cfg_ready, o_port_run}), 16'h0003);
    frame(0);
    frame(1);
    wr(REG_FAIL_LIM, 16'h0002, 16'h0002);
    for (int k = 0; k < 3; k++)
    begin
      pulse(k == 2);
      tick();
      tick();
      e = 16'({k == 1, k != 1});
      chk("shut", 16'({o_ports_shut, o_port_run}), e);
    end
    wr(REG_FAIL_LIM, 16'h0000, 16'h0000);
    repeat (3) pulse(0);
    tick();
    chk("no_limit", 16'(o_ports_shut), 16'h0000);
    final_report();
  end
endmodule : sport_cfg_test
